// [common/impw_pkg.sv]
// Shared constants and types for the interleaved multiphase PWM timing block
package impw_pkg;
  // Structure
  localparam int NCH   = 4;               // Phase channels built
  localparam int PER_W = 16;              // Switching-period counter width
  localparam int CUR_W = 12;              // Sampled current word width
  localparam int SUM_W = CUR_W + 2;       // Sum of four samples

  // Clock rate and timing figures
  localparam int CLK_MHZ   = 125;
  localparam int SETTLE_NS = 200;         // Sense settling before sample and hold
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int STRAP_NS  = 1000;        // Strap pins left undriven before sampling
  localparam int STRAP_CYC = (STRAP_NS * CLK_MHZ + 999) / 1000;

  // Divide by three as multiply and shift
  localparam logic [16:0] THIRD_MUL   = 17'h0_5556;
  localparam int          THIRD_SHIFT = 16;

  // Balance filter strength, as a right shift
  localparam int LPF_SHIFT = 3;

  // Active-channel masks and counts
  localparam logic [NCH-1:0] MASK_FOUR  = 4'hf;
  localparam logic [NCH-1:0] MASK_THREE = 4'h7;
  localparam logic [NCH-1:0] MASK_TWO   = 4'h3;
  localparam logic [2:0]     COUNT_FOUR  = 3'h4;
  localparam logic [2:0]     COUNT_THREE = 3'h3;
  localparam logic [2:0]     COUNT_TWO   = 3'h2;

  // Strap bit positions on the strap pin pair
  localparam int STRAP_P3 = 0;
  localparam int STRAP_P4 = 1;

  typedef enum logic [1:0] {
    MODE_FOUR  = 2'b00,
    MODE_TWO   = 2'b01,
    MODE_THREE = 2'b10
  } impw_mode_e;

  typedef enum logic [1:0] {
    ST_STRAP = 2'b00,
    ST_RUN   = 2'b01
  } impw_state_e;
endpackage

// [core/impw_lpf.sv]
// First-order low-pass filter for one channel's balance error current
`timescale 1ns/1ps
module impw_lpf
  import impw_pkg::*;
#(
  parameter int W     = CUR_W + 1,
  parameter int SHIFT = LPF_SHIFT
) (
  // Clock and reset
  input  wire logic                CLK_IN,
  input  wire logic                RESET_IN,
  // Control
  input  wire logic                CLEAR_IN,
  input  wire logic                UPDATE_IN,
  // Data
  input  wire logic signed [W-1:0] ERR_IN,
  output logic signed [W-1:0]      FILT_OUT
);
  logic signed [W:0]   diff;
  logic signed [W:0]   step;
  logic signed [W-1:0] filt_next;

  // One step toward the input per switching cycle; truncation leaves a small bias
  assign diff      = ERR_IN - FILT_OUT;
  assign step      = diff >>> SHIFT;
  assign filt_next = FILT_OUT + step[W-1:0];

  // Cleared channels hold zero so they add no correction
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN || CLEAR_IN) begin
      FILT_OUT <= '0;
    end else if (UPDATE_IN) begin
      FILT_OUT <= filt_next;
    end
  end
endmodule

// [core/impw_core.sv]
// Interleaved multiphase PWM timing with strap channel select and current balance
// Operation
// - No strap: all four channels run
// - Cycle spans phase one falling edges
// - Period clock drives phase one low
// - Four channels: terminations a quarter apart
// - Phase three strapped high: two channels, half
// - Phase four strapped high: three channels, third
// - Falling edge forces quarter-cycle low time
// - After forced off, ramp crossing sets high
// - High holds until own next termination
// - Sense only inside forced off window
// - Sample and hold once per cycle
// - Average sums active samples over count
// - Error is sample minus average
// - Filtered error corrects duty toward balance; the core only outputs it on BALANCE_CORR_OUT
// - Deselected channels excluded and idle
`timescale 1ns/1ps
module impw_core
  import impw_pkg::*;
(
  // Clock and reset
  input  wire logic                   CLK_IN,
  input  wire logic                   RESET_IN,
  // Switching period in clock cycles, set from freq_set_pin
  input  wire logic [PER_W-1:0]       PERIOD_CYCLES_IN,
  // Per-channel ramp crossing and sampled current words
  input  wire logic [NCH-1:0]         RAMP_CROSS_IN,
  input  wire logic [NCH*CUR_W-1:0]   CURRENT_SENSE_IN,
  // Pin levels of phase_out_3 and phase_out_4 for strapping
  input  wire logic [1:0]             STRAP_PIN_IN,
  // Phase outputs with enables
  output logic [NCH-1:0]              PHASE_OUT,
  output logic [NCH-1:0]              PHASE_OE_OUT,
  // Balance results
  output logic [CUR_W-1:0]            AVERAGE_CURRENT_OUT,
  output logic [NCH*(CUR_W+1)-1:0]    BALANCE_CORR_OUT,
  // Status
  output logic [2:0]                  CHANNEL_COUNT_OUT,
  output logic                        CYCLE_START_OUT
);
  // Strap synchroniser and startup state
  logic [1:0]           strap_s1_reg;
  logic [1:0]           strap_s2_reg;
  impw_state_e          state_reg;
  impw_state_e          state_next;
  logic [7:0]           strap_cnt_reg;
  impw_mode_e           mode_reg;
  impw_mode_e           mode_next;
  logic                 strap_done;
  logic                 run;
  logic [NCH-1:0]       active;
  logic [2:0]           count_next;

  // Period timing
  logic [PER_W-1:0]     period_reg;
  logic [PER_W-1:0]     cnt_reg;
  logic [PER_W-1:0]     cnt_next;
  logic                 wrap;
  logic                 cycle_start;
  logic [PER_W-1:0]     step;
  logic [PER_W-1:0]     quarter;
  logic [31:0]          period_third;

  // Per-channel wires
  logic [NCH-1:0]       term;
  logic [NCH-1:0]       phase_q;
  logic [CUR_W-1:0]     held [NCH];
  logic [SUM_W-1:0]     sum;
  logic [31:0]          sum_third;
  logic [CUR_W-1:0]     avg_next;
  logic [CUR_W-1:0]     avg_reg;

  function automatic logic [31:0] third_of(input logic [31:0] x);
    logic [48:0] p;
    p = {17'h0_0000, x} * {32'h0000_0000, THIRD_MUL};
    return p[THIRD_SHIFT +: 32];
  endfunction

  // Strap pins come from the board, so two flops before any use
  always_ff @(posedge CLK_IN) begin
    strap_s1_reg <= STRAP_PIN_IN;
    strap_s2_reg <= strap_s1_reg;
  end

  // Phase three strap wins over phase four; with neither, four channels
  assign strap_done = (state_reg == ST_STRAP) && (strap_cnt_reg == 8'(STRAP_CYC));
  assign mode_next  = strap_s2_reg[STRAP_P3] ? MODE_TWO :
                      strap_s2_reg[STRAP_P4] ? MODE_THREE :
                      MODE_FOUR;
  assign state_next = strap_done ? ST_RUN : state_reg;
  assign run        = (state_reg == ST_RUN);

  // Outputs stay undriven after reset so a strap to the supply can be read
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      state_reg     <= ST_STRAP;
      strap_cnt_reg <= '0;
      mode_reg      <= MODE_FOUR;
    end else begin
      state_reg <= state_next;
      if (!run) begin
        strap_cnt_reg <= strap_cnt_reg + 8'h01;
      end
      if (strap_done) begin
        mode_reg <= mode_next;
      end
    end
  end

  // Active channels and spacing between terminations
  always_comb begin
    case (mode_reg)
      MODE_TWO: begin
        active     = MASK_TWO;
        count_next = COUNT_TWO;
        step       = period_reg >> 1;
      end
      MODE_THREE: begin
        active     = MASK_THREE;
        count_next = COUNT_THREE;
        step       = period_third[PER_W-1:0];
      end
      default: begin
        active     = MASK_FOUR;
        count_next = COUNT_FOUR;
        step       = period_reg >> 2;
      end
    endcase
  end
  assign period_third = third_of({16'h0000, period_reg});
  assign quarter      = period_reg >> 2;

  // Cycle counter; zero is the phase one termination instant
  assign wrap        = (cnt_reg >= period_reg - 16'h0001);
  assign cnt_next    = wrap ? '0 : cnt_reg + 16'h0001;
  assign cycle_start = run && (cnt_reg == '0);

  // Period is picked up only at a wrap so a cycle never changes length midway
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN || !run) begin
      cnt_reg    <= '0;
      period_reg <= PERIOD_CYCLES_IN;
    end else begin
      cnt_reg <= cnt_next;
      if (wrap) begin
        period_reg <= PERIOD_CYCLES_IN;
      end
    end
  end

  // Per-channel timing, sampling and balance
  for (genvar k = 0; k < NCH; k++) begin : g_ch
    logic [PER_W-1:0]       off;
    logic [PER_W-1:0]       foff_cnt_reg;
    logic                   forced_reg;
    logic                   taken_reg;
    logic                   phase_reg;
    logic                   oe_reg;
    logic [CUR_W-1:0]       held_reg;
    logic                   sample_now;
    logic                   forced_end;
    logic signed [CUR_W:0]  err;
    logic                   clear;

    assign off        = PER_W'(step * k);
    assign term[k]    = run && active[k] && (cnt_reg == off);
    assign forced_end = (foff_cnt_reg + 16'h0001 >= quarter);
    // Sample after settling, or at the window end if the window is shorter
    assign sample_now = forced_reg && !taken_reg && run && active[k] &&
                        ((foff_cnt_reg == PER_W'(SETTLE_CYC)) || forced_end);

    // Forced off starts at each termination and lasts a quarter cycle
    always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
        foff_cnt_reg <= '0;
        forced_reg   <= 1'b1;
        taken_reg    <= 1'b0;
      end else if (term[k]) begin
        foff_cnt_reg <= '0;
        forced_reg   <= 1'b1;
        taken_reg    <= 1'b0;
      end else if (forced_reg && run && active[k]) begin
        foff_cnt_reg <= foff_cnt_reg + 16'h0001;
        forced_reg   <= !forced_end;
        taken_reg    <= taken_reg || sample_now;
      end
    end

    // Termination drives low; ramp crossing sets high once forced off is over
    always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
        phase_reg <= 1'b0;
        oe_reg    <= 1'b0;
      end else begin
        oe_reg <= run && active[k];
        if (term[k]) begin
          phase_reg <= 1'b0;
        end else if (!forced_reg && run && active[k] && RAMP_CROSS_IN[k]) begin
          phase_reg <= 1'b1;
        end
      end
    end

    // Sample and hold of the sensed current word
    always_ff @(posedge CLK_IN) begin
      if (RESET_IN) begin
        held_reg <= '0;
      end else if (sample_now) begin
        held_reg <= CURRENT_SENSE_IN[k*CUR_W +: CUR_W];
      end
    end

    assign held[k]         = active[k] ? held_reg : '0;
    assign err             = $signed({1'b0, held_reg}) - $signed({1'b0, avg_reg});
    assign clear           = !run || !active[k];
    assign phase_q[k]      = phase_reg;
    assign PHASE_OE_OUT[k] = oe_reg;

    // Positive output means this channel carries too much; subtract it from comp
    impw_lpf #(
      .W     (CUR_W + 1),
      .SHIFT (LPF_SHIFT)
    ) u_lpf (
      .CLK_IN   (CLK_IN),
      .RESET_IN (RESET_IN),
      .CLEAR_IN (clear),
      .UPDATE_IN(cycle_start),
      .ERR_IN   (err),
      .FILT_OUT (BALANCE_CORR_OUT[k*(CUR_W+1) +: CUR_W+1])
    );
  end

  // Sum of active samples only, divided by the active count
  always_comb begin
    sum = '0;
    for (int i = 0; i < NCH; i++) begin
      sum = sum + SUM_W'(held[i]);
    end
  end
  assign sum_third = third_of({18'h0_0000, sum});
  assign avg_next  = (mode_reg == MODE_TWO)   ? CUR_W'(sum >> 1) :
                     (mode_reg == MODE_THREE) ? sum_third[CUR_W-1:0] :
                     CUR_W'(sum >> 2);

  // Average refreshed once per cycle, from samples held in the previous cycle
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      avg_reg           <= '0;
      CHANNEL_COUNT_OUT <= '0;
      CYCLE_START_OUT   <= 1'b0;
    end else begin
      if (cycle_start) begin
        avg_reg <= avg_next;
      end
      CHANNEL_COUNT_OUT <= run ? count_next : 3'h0;
      CYCLE_START_OUT   <= cycle_start;
    end
  end

  assign PHASE_OUT           = phase_q;
  assign AVERAGE_CURRENT_OUT = avg_reg;
endmodule

// [tb/impw_core_sva.sv]
// Port-level assertions for the interleaved multiphase PWM timing block
`timescale 1ns/1ps
module impw_core_chk
  import impw_pkg::*;
(
  // Clock and reset
  input wire logic                     CLK_IN,
  input wire logic                     RESET_IN,
  // Inputs seen by the block
  input wire logic [PER_W-1:0]         PERIOD_CYCLES_IN,
  input wire logic [NCH-1:0]           RAMP_CROSS_IN,
  // Outputs of the block
  input wire logic [NCH-1:0]           PHASE_OUT,
  input wire logic [NCH-1:0]           PHASE_OE_OUT,
  input wire logic [NCH*(CUR_W+1)-1:0] BALANCE_CORR_OUT,
  input wire logic [2:0]               CHANNEL_COUNT_OUT,
  input wire logic                     CYCLE_START_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  logic [PER_W-1:0] lo_cnt_reg;
  // Low time of phase one, judged at the rise; a run-time period has no fixed repeat count
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN || PHASE_OUT[0]) begin
      lo_cnt_reg <= '0;
    end else begin
      lo_cnt_reg <= lo_cnt_reg + 16'h0001;
    end
  end
  // Steps of a cycle start
  sequence s_fall0;
    $fell(PHASE_OUT[0]);
  endsequence
  sequence s_quiet6;
    !CYCLE_START_OUT [*6];
  endsequence
  chk_start_fall: assert property (s_fall0 |-> CYCLE_START_OUT)
    else $error("phase one fell without a cycle start");
  chk_start_gap: assert property (CYCLE_START_OUT |=> s_quiet6)
    else $error("cycle starts too close");
  chk_low_time: assert property (
    $rose(PHASE_OUT[0]) |-> lo_cnt_reg >= (PERIOD_CYCLES_IN >> 2))
    else $error("phase one low time short");
  chk_rise_ramp: assert property (
    (PHASE_OUT & ~$past(PHASE_OUT) & ~$past(RAMP_CROSS_IN)) == 4'h0)
    else $error("phase rose without ramp crossing");
  chk_count_fixed: assert property (
    CHANNEL_COUNT_OUT != 3'h0 |=> $stable(CHANNEL_COUNT_OUT))
    else $error("channel count changed in run");
  chk_count_legal: assert property (
    CHANNEL_COUNT_OUT inside {3'h0, 3'h2, 3'h3, 3'h4})
    else $error("illegal channel count");
  chk_two_idle: assert property (CHANNEL_COUNT_OUT == 3'h2 |->
    PHASE_OE_OUT[3:2] == 2'h0 && BALANCE_CORR_OUT[51:26] == '0)
    else $error("deselected channel active in two-channel mode");
  chk_three_idle: assert property (CHANNEL_COUNT_OUT == 3'h3 |->
    !PHASE_OE_OUT[3] && BALANCE_CORR_OUT[51:39] == '0)
    else $error("deselected channel active in three-channel mode");
endmodule
bind impw_core impw_core_chk impw_core_chk_i (
  .CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .PERIOD_CYCLES_IN(PERIOD_CYCLES_IN),
  .RAMP_CROSS_IN(RAMP_CROSS_IN), .PHASE_OUT(PHASE_OUT), .PHASE_OE_OUT(PHASE_OE_OUT),
  .BALANCE_CORR_OUT(BALANCE_CORR_OUT), .CHANNEL_COUNT_OUT(CHANNEL_COUNT_OUT),
  .CYCLE_START_OUT(CYCLE_START_OUT));

// [tb/impw_drv_model.sv]
// Gate driver model: current seen only while the lower switch conducts
`timescale 1ns/1ps
module impw_drv_model
  import impw_pkg::*;
(
  // Phase commands
  input  wire logic [NCH-1:0]       phase_in,
  input  wire logic [NCH-1:0]       oe_in,
  // Sense words
  output logic [NCH*CUR_W-1:0]      sense_out
);
  // Inverse value outside conduction, so a mistimed sample is seen
  for (genvar k = 0; k < NCH; k++) begin : g_ch
    assign sense_out[k*CUR_W+:CUR_W] = (oe_in[k] && !phase_in[k]) ?
      CUR_W'(100 * (k + 1)) : ~CUR_W'(100 * (k + 1));
  end
endmodule

// [tb/testbench.sv]
// Self-checking bench for the interleaved multiphase PWM timing block
`timescale 1ns/1ps
module testbench;
  import impw_pkg::*;
  localparam int P = 40;
  logic                     clk_in = 1'b0;
  logic                     reset_in = 1'b1;
  logic [1:0]               strap_in = 2'b00;
  logic [NCH-1:0]           ramp_in = 4'hf;
  logic [PER_W-1:0]         period_in = PER_W'(P);
  logic [NCH-1:0]           phase_out;
  logic [NCH-1:0]           oe_out;
  logic [NCH*CUR_W-1:0]     sense;
  logic [CUR_W-1:0]         avg_out;
  logic [NCH*(CUR_W+1)-1:0] corr_out;
  logic [2:0]               count_out;
  logic                     start_out;
  int                       bad_count = 0;
  int                       n_checks = 0;
  impw_core impw_core_i (.CLK_IN(clk_in), .RESET_IN(reset_in), .PERIOD_CYCLES_IN(period_in),
    .RAMP_CROSS_IN(ramp_in), .CURRENT_SENSE_IN(sense), .STRAP_PIN_IN(strap_in),
    .PHASE_OUT(phase_out), .PHASE_OE_OUT(oe_out), .AVERAGE_CURRENT_OUT(avg_out),
    .BALANCE_CORR_OUT(corr_out), .CHANNEL_COUNT_OUT(count_out), .CYCLE_START_OUT(start_out));
  impw_drv_model impw_drv_model_i (.phase_in(phase_out), .oe_in(oe_out), .sense_out(sense));
  initial begin
    forever #4 clk_in = ~clk_in;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // A wait that runs out counts as a mismatch and ends the run
  task automatic limit_hit();
    bad_count++;
    final_report();
  endtask
  // Reset with a strap level, then let a few cycles settle the averages
  task automatic do_reset(input logic [1:0] strap);
    int i;
    @(negedge clk_in);
    reset_in = 1'b1;
    strap_in = strap;
    repeat (3) @(negedge clk_in);
    reset_in = 1'b0;
    for (i = 0; i < 300 && count_out === 3'h0; i++) @(negedge clk_in);
    if (i == 300) begin
      limit_hit();
    end
    repeat (6 * P) @(negedge clk_in);
  endtask
  // Falling edges over two periods give spacing and period
  task automatic check_mode(input logic [2:0] n, input logic [3:0] mask, input int step,
                            input logic [CUR_W-1:0] avg);
    int f[4];
    int p0;
    int i;
    int k;
    logic [3:0] prev;
    f = '{-1, -1, -1, -1};
    p0 = -1;
    prev = phase_out;
    for (i = 0; i < 2 * P; i++) begin
      @(negedge clk_in);
      for (k = 0; k < 4; k++) begin
        if (prev[k] === 1'b1 && phase_out[k] === 1'b0) begin
          if (f[k] < 0) f[k] = i;
          else if (k == 0 && p0 < 0) p0 = i;
        end
      end
      prev = phase_out;
    end
    chk(count_out, n);
    chk(oe_out, mask);
    chk(16'(p0 - f[0]), 16'(P));
    for (k = 1; k < n; k++) chk(16'((f[k] - f[0] + P) % P), 16'(k * step));
    chk(avg_out, avg);
    chk(corr_out[CUR_W], 1'b1);
    // Highest active channel carries the most, so its correction is positive
    chk(corr_out[n * (CUR_W + 1) - 1], 1'b0);
  endtask
  task automatic sc_four();
    do_reset(2'b00);
    check_mode(3'h4, 4'hf, P / 4, 12'h0fa);
  endtask
  task automatic sc_two();
    do_reset(2'b11); // Phase four tied high as well
    check_mode(3'h2, 4'h3, P / 2, 12'h096);
  endtask
  task automatic sc_three();
    do_reset(2'b10);
    check_mode(3'h3, 4'h7, P / 3, 12'h0c8);
  endtask
  // A new period is taken at the wrap and sets the next cycle length
  task automatic sc_period();
    int i;
    for (i = 0; i < 2 * P && phase_out[0] !== 1'b1; i++) @(negedge clk_in);
    if (i == 2 * P) begin
      limit_hit();
    end
    // One more edge so the low-time check judges this rise on the old period
    @(negedge clk_in);
    period_in = PER_W'(P + 8);
    for (i = 0; i < 2 * P && start_out !== 1'b1; i++) @(negedge clk_in);
    if (i == 2 * P) begin
      limit_hit();
    end
    @(negedge clk_in);
    for (i = 1; i < 2 * P && start_out !== 1'b1; i++) @(negedge clk_in);
    if (i == 2 * P) begin
      limit_hit();
    end
    chk(16'(i), 16'(P + 8));
  endtask
  // No crossing keeps phases low; a dropped crossing does not end a high pulse
  task automatic sc_hold();
    int i;
    ramp_in = 4'h0;
    repeat (2 * P) @(negedge clk_in);
    chk(phase_out, 4'h0);
    ramp_in = 4'hf;
    for (i = 0; i < P && phase_out[0] !== 1'b1; i++) @(negedge clk_in);
    if (i == P) begin
      limit_hit();
    end
    ramp_in = 4'h0;
    for (i = 0; i < P && phase_out[0] === 1'b1; i++) @(negedge clk_in);
    if (i == P) begin
      limit_hit();
    end
    chk(start_out, 1'b1);
    ramp_in = 4'hf;
    for (i = 0; i < P && phase_out[0] === 1'b0; i++) @(negedge clk_in);
    if (i == P) begin
      limit_hit();
    end
    chk(16'(i >= P / 4 && i < P), 16'h0001);
  endtask
  // Strap change in run is ignored
  task automatic sc_restrap();
    strap_in = 2'b01;
    repeat (P) @(negedge clk_in);
    chk(count_out, 3'h4);
    chk(oe_out, 4'hf);
  endtask
  initial begin
    sc_four();
    sc_hold();
    sc_restrap();
    sc_two();
    sc_three();
    sc_period();
    final_report();
  end
endmodule
